// >>> inc/ebl_params.svh
// Constants of the serial EEPROM auto-boot loader.
// Assumes inclusion by the loader module only.
`ifndef EBL_PARAMS_SVH
`define EBL_PARAMS_SVH

// Fixed memory read opcode sent first
`define EBL_READ_OPCODE   8'h03
// Command byte classes
`define EBL_WR_MASK       8'hC0
`define EBL_WR_MATCH      8'h40
`define EBL_START_CONV    8'hE8
`define EBL_STOP_CMD      8'h78
`define EBL_STOP_BIT      8
`define EBL_DATA_BYTES    2'h3
// EEPROM address width sent after the opcode
`define EBL_ADDR_BITS     8
// Timing: master clock and serial clock half period
`define EBL_CLK_PERIOD_NS 10
`define EBL_SCLK_HALF_NS  80
`define EBL_SCLK_HALF_CYC ((`EBL_SCLK_HALF_NS + `EBL_CLK_PERIOD_NS - 1) / `EBL_CLK_PERIOD_NS)
// Reset values
`define EBL_CS_N_RST      1'b1

`endif

// >>> inc/ebl_pkg.sv
// Types of the serial EEPROM auto-boot loader.
// Assumes nothing beyond the constants header.
package ebl_pkg;

  // Loader states, Gray coded along the boot path
  typedef enum logic [2:0] {
    EBL_IDLE   = 3'h0,
    EBL_OPCODE = 3'h1,
    EBL_ADDR   = 3'h3,
    EBL_FETCH  = 3'h2,
    EBL_WAIT   = 3'h6,
    EBL_DONE   = 3'h7
  } ebl_state_t;

  // Whole state of the loader
  typedef struct packed {
    ebl_state_t  state;
    logic [2:0]  mode_s;
    logic        mode_f;
    logic [2:0]  sdi_s;
    logic        sdi_f;
    logic [7:0]  div;
    logic        sclk;
    logic [4:0]  bits;
    logic [7:0]  sh_out;
    logic [7:0]  sh_in;
    logic [1:0]  rem;
    logic [7:0]  cmd;
    logic [23:0] data;
    logic        pend;
    logic        cs_n;
    logic        drive;
    logic        done;
  } ebl_regs_t;

endpackage : ebl_pkg

// >>> rtl/ebl_boot_loader.sv
// Auto-boot loader: fetches a command stream from a serial EEPROM.
// Assumes a command executor on the same clock that takes each
// command through cmd_valid/cmd_ready, and pad cells that resolve
// each pin from its output enable.
`timescale 1ns/10ps
`default_nettype none
`include "ebl_params.svh"

// Notes on behaviour
// - A high boot strap starts auto-boot and the fetch from the EEPROM.
// - In auto-boot the chip select and serial clock pins become outputs.
// - The fetch asserts chip select, runs the clock and shifts out a read.
// - Bytes returned on the data input are captured as they are clocked.
// - The first byte sent is the fixed read opcode 00000011.
// - Fetched data goes to the executor to replace register reset values.
// - Every host command is accepted, not a subset of them.
// - A write command byte takes three data bytes, most significant first.
// - Command 48 with three bytes loads the voltage gain register.
// - Command 40 with three bytes writes the configuration register.
// - Command 74 with three bytes writes the interrupt mask register.
// - Command E8 carries no data bytes and starts conversions.
// - Command 78 with the stop bit set ends the boot and the fetching.
module ebl_boot_loader
  import ebl_pkg::*;
#(
  parameter int SCLK_HALF_CYC = `EBL_SCLK_HALF_CYC,
  parameter int ADDR_BITS     = `EBL_ADDR_BITS
) (
  input  wire logic        clock,         // Master clock
  input  wire logic        rst,           // Sync reset, high
  input  wire logic        clk_en,        // Freezes all state when low
  input  wire logic        boot_mode_pin, // Boot strap pin
  input  wire logic        sdi_pin,       // Serial data from EEPROM
  output logic             cs_n_out,      // Chip select, low active
  output logic             cs_n_oe,       // Chip select drive enable
  output logic             sclk_out,      // Serial clock
  output logic             sclk_oe,       // Serial clock drive enable
  output logic             sdo_out,       // Serial data to EEPROM
  output logic             sdo_oe,        // Serial data drive enable
  output logic             cmd_valid,     // Command ready for executor
  input  wire logic        cmd_ready,     // Executor takes command
  output logic [7:0]       cmd_opcode,    // Command byte
  output logic [23:0]      cmd_data,      // Write data, MSB first
  output logic             cmd_has_data,  // Command carries data
  output logic             boot_active,   // Boot sequence running
  output logic             boot_done      // Stop write executed
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // mask write
  // Command bytes 01xxxxxx are register writes with data bytes
  function automatic logic is_write(input logic [7:0] c);
    return (c & `EBL_WR_MASK) == `EBL_WR_MATCH;
  endfunction : is_write

  // stop write decode
  // Control register write with the stop bit set
  function automatic logic is_stop(input logic [7:0] c,
                                   input logic [23:0] d);
    return (c == `EBL_STOP_CMD) && d[`EBL_STOP_BIT];
  endfunction : is_stop

  // ****************************************************************
  // State and derived terms
  // ****************************************************************

  localparam logic [7:0] HALF_M1 = 8'(SCLK_HALF_CYC - 1);
  localparam logic [4:0] ADDR_M1 = 5'(ADDR_BITS - 1);

  localparam ebl_regs_t RST_VAL = '{
    state: EBL_IDLE,
    cs_n:  `EBL_CS_N_RST,
    default: '0
  };

  ebl_regs_t  st_reg;
  ebl_regs_t  st_next;
  logic       clk_run;
  logic       term;
  logic       fall_evt;
  logic [7:0] rx_byte;

  // Serial clock runs only while bits move
  assign clk_run = (st_reg.state == EBL_OPCODE) ||
                   (st_reg.state == EBL_ADDR) ||
                   (st_reg.state == EBL_FETCH);
  assign term     = (st_reg.div == HALF_M1);
  // End of high phase: sample input, then shift output
  assign fall_evt = clk_run && st_reg.sclk && term;
  assign rx_byte  = {st_reg.sh_in[6:0], st_reg.sdi_f};

  // ****************************************************************
  // Next state
  // ****************************************************************

  // Synchronisers, clock divider and boot sequencer
  always_comb begin
    st_next = st_reg;
    // Pin inputs count once second and third stage agree
    st_next.mode_s = {st_reg.mode_s[1:0], boot_mode_pin};
    if (st_reg.mode_s[1] == st_reg.mode_s[2]) begin
      st_next.mode_f = st_reg.mode_s[2];
    end
    st_next.sdi_s = {st_reg.sdi_s[1:0], sdi_pin};
    if (st_reg.sdi_s[1] == st_reg.sdi_s[2]) begin
      st_next.sdi_f = st_reg.sdi_s[2];
    end
    if (clk_run) begin
      if (term) begin
        st_next.div  = 8'h00;
        st_next.sclk = ~st_reg.sclk;
      end else begin
        st_next.div = st_reg.div + 8'h01;
      end
    end else begin
      st_next.div  = 8'h00;
      st_next.sclk = 1'b0;
    end
    unique case (st_reg.state)
      EBL_IDLE: begin
        if (st_reg.mode_f && !st_reg.done) begin
          st_next.state  = EBL_OPCODE;
          st_next.drive  = 1'b1;
          st_next.cs_n   = 1'b0;
          st_next.sh_out = `EBL_READ_OPCODE;
          st_next.bits   = 5'h00;
        end
      end
      EBL_OPCODE: begin
        if (fall_evt) begin
          st_next.sh_out = {st_reg.sh_out[6:0], 1'b0};
          st_next.bits   = st_reg.bits + 5'h01;
          if (st_reg.bits == 5'h07) begin
            st_next.bits  = 5'h00;
            st_next.state = EBL_ADDR;
          end
        end
      end
      EBL_ADDR: begin
        if (fall_evt) begin
          st_next.bits = st_reg.bits + 5'h01;
          if (st_reg.bits == ADDR_M1) begin
            st_next.bits  = 5'h00;
            st_next.state = EBL_FETCH;
          end
        end
      end
      EBL_FETCH: begin
        if (fall_evt) begin
          st_next.sh_in = rx_byte;
          st_next.bits  = st_reg.bits + 5'h01;
          if (st_reg.bits == 5'h07) begin
            st_next.bits = 5'h00;
            if (st_reg.rem == 2'h0) begin
              st_next.cmd  = rx_byte;
              st_next.data = 24'h000000;
              if (is_write(rx_byte)) begin
                st_next.rem = `EBL_DATA_BYTES;
              end else begin
                st_next.pend  = 1'b1;
                st_next.state = EBL_WAIT;
              end
            end else begin
              st_next.data = {st_reg.data[15:0], rx_byte};
              st_next.rem  = st_reg.rem - 2'h1;
              if (st_reg.rem == 2'h1) begin
                st_next.pend  = 1'b1;
                st_next.state = EBL_WAIT;
              end
            end
          end
        end
      end
      EBL_WAIT: begin
        if (cmd_ready) begin
          st_next.pend = 1'b0;
          if (is_stop(st_reg.cmd, st_reg.data)) begin
            st_next.state = EBL_DONE;
            st_next.cs_n  = 1'b1;
            st_next.done  = 1'b1;
          end else begin
            st_next.state = EBL_FETCH;
          end
        end
      end
      EBL_DONE: begin
        // Stays here until reset
      end
      default: begin
        st_next = RST_VAL;
      end
    endcase
  end

  // Register the state
  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= RST_VAL;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Pins driven from flops
  assign cs_n_out     = st_reg.cs_n;
  assign cs_n_oe      = st_reg.drive;
  assign sclk_out     = st_reg.sclk;
  assign sclk_oe      = st_reg.drive;
  assign sdo_out      = st_reg.sh_out[7];
  assign sdo_oe       = st_reg.drive;
  assign cmd_valid    = st_reg.pend;
  assign cmd_opcode   = st_reg.cmd;
  assign cmd_data     = st_reg.data;
  assign cmd_has_data = is_write(st_reg.cmd);
  assign boot_active  = st_reg.drive && !st_reg.done;
  assign boot_done    = st_reg.done;

  // ****************************************************************
  // Assertions
  // ****************************************************************

  // Bits clocked in since the last command was taken
  logic [5:0] bits_seen;
  always_ff @(posedge clock) begin
    if (rst) begin
      bits_seen <= 6'h00;
    end else if (clk_en) begin
      if (st_reg.state == EBL_WAIT && st_next.state == EBL_FETCH) begin
        bits_seen <= 6'h00;
      end else if (fall_evt && st_reg.state == EBL_FETCH) begin
        bits_seen <= 6'(bits_seen + 6'h01);
      end
    end
  end

  a_strap_start: assert property (@(posedge clock) disable iff (rst)
    clk_en && st_reg.state == EBL_IDLE && st_reg.mode_f && !st_reg.done
    |=> st_reg.state == EBL_OPCODE && !cs_n_out)
    else $error("boot did not start on high strap");

  a_pins_output: assert property (@(posedge clock) disable iff (rst)
    st_reg.state != EBL_IDLE |-> cs_n_oe && sclk_oe && sdo_oe)
    else $error("pins not driven during boot");

  a_cs_held_low: assert property (@(posedge clock) disable iff (rst)
    st_reg.state inside {EBL_OPCODE, EBL_ADDR, EBL_FETCH, EBL_WAIT} |-> !cs_n_out)
    else $error("chip select high mid stream");

  a_opcode_first: assert property (@(posedge clock) disable iff (rst)
    $rose(st_reg.state == EBL_OPCODE) |-> st_reg.sh_out == `EBL_READ_OPCODE)
    else $error("read opcode not loaded");

  a_cmd_length: assert property (@(posedge clock) disable iff (rst)
    $rose(cmd_valid) |-> bits_seen == (cmd_has_data ? 6'h20 : 6'h08))
    else $error("command length wrong");

  a_single_byte: assert property (@(posedge clock) disable iff (rst)
    $rose(cmd_valid) && cmd_opcode == `EBL_START_CONV
    |-> !cmd_has_data && bits_seen == 6'h08 && cmd_data == 24'h000000)
    else $error("start command took data");

  a_cmd_hold: assert property (@(posedge clock) disable iff (rst)
    cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_opcode) && $stable(cmd_data))
    else $error("command dropped before taken");

  a_stop_ends: assert property (@(posedge clock) disable iff (rst)
    clk_en && cmd_valid && cmd_ready && is_stop(cmd_opcode, cmd_data)
    |=> boot_done && cs_n_out && !sclk_out)
    else $error("stop did not end boot");

  a_clock_paused: assert property (@(posedge clock) disable iff (rst)
    st_reg.state == EBL_WAIT |-> !sclk_out)
    else $error("clock runs while waiting");

  c_boot_done: cover property (@(posedge clock) disable iff (rst)
    $rose(boot_done));
  c_start_conv: cover property (@(posedge clock) disable iff (rst)
    cmd_valid && cmd_ready && cmd_opcode == `EBL_START_CONV);
  c_stalled_write: cover property (@(posedge clock) disable iff (rst)
    cmd_valid && cmd_has_data && !cmd_ready ##1 cmd_ready);

endmodule : ebl_boot_loader
`default_nettype wire

// >>> verification/ebl_eeprom_model.sv
// Serial EEPROM model that answers the boot loader's read.
// Assumes mode 0 framing: sample on clock rise, change on clock fall.
`timescale 1ns/10ps
`default_nettype none
module ebl_eeprom_model #(
  parameter int ADDR_BITS = 8
) (
  input  wire logic cs_n, // Chip select, low active
  input  wire logic sclk, // Serial clock from loader
  input  wire logic sdo,  // Serial data from loader
  output logic      sdi   // Serial data to loader
);
  logic [7:0]  mem [0:31]; // Stored boot stream
  logic [7:0]  opcode;     // Received command byte
  logic [15:0] addr;       // Received start address
  int          rises;      // Clock rises while selected
  int          idx;        // Stream bit index
  initial begin
    sdi = 1'b0;
    opcode = 8'h00;
    addr = 16'h0000;
    rises = 0;
  end
  // header taken in, command then address
  always @(posedge sclk) begin
    if (!cs_n) begin
      if (rises < 8) opcode = {opcode[6:0], sdo};
      else if (rises < 8 + ADDR_BITS) addr = {addr[14:0], sdo};
      rises = rises + 1;
    end
  end
  // bytes sent MSB first, auto-incrementing
  // A released line flips so that no stale value lingers
  always @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      sdi = ~sdi;
    end else if (rises >= 8 + ADDR_BITS) begin
      idx = rises - 8 - ADDR_BITS + int'(addr) * 8;
      sdi = mem[idx / 8][7 - idx % 8];
    end
  end
endmodule : ebl_eeprom_model
`default_nettype wire

// >>> verification/ebl_boot_loader_test.sv
// Self-checking bench of the boot loader with an EEPROM model.
// Assumes the loader and its package; the bench acts as executor.
`timescale 1ns/10ps
`default_nettype none
module ebl_boot_loader_test;
  import ebl_pkg::*;
  logic        clock, rst, clk_en, boot_mode_pin, cmd_ready;
  wire         sdi_pin;
  logic        cs_n_out, cs_n_oe, sclk_out, sclk_oe, sdo_out, sdo_oe;
  logic        cmd_valid, cmd_has_data, boot_active, boot_done;
  logic [7:0]  cmd_opcode;
  logic [23:0] cmd_data;
  int          errors, total_checks, cycles, nbytes, bad;
  logic [7:0]  exp_cmd [0:6] = '{8'h40, 8'h44, 8'h48, 8'h4C, 8'h74, 8'hE8, 8'h78};
  logic [23:0] exp_dat [0:6] = '{24'h000061, 24'h7FC4A9, 24'hFFB253, 24'h007D00,
                                 24'h000004, 24'h000000, 24'h000100};
  // ****************************************
  // Design, pads and EEPROM
  // ****************************************
  ebl_boot_loader #(.SCLK_HALF_CYC(5), .ADDR_BITS(8)) ebl_boot_loader_i (
    .clock(clock), .rst(rst), .clk_en(clk_en), .boot_mode_pin(boot_mode_pin),
    .sdi_pin(sdi_pin), .cs_n_out(cs_n_out), .cs_n_oe(cs_n_oe), .sclk_out(sclk_out),
    .sclk_oe(sclk_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_opcode(cmd_opcode), .cmd_data(cmd_data),
    .cmd_has_data(cmd_has_data), .boot_active(boot_active), .boot_done(boot_done));
  ebl_eeprom_model #(.ADDR_BITS(8)) ebl_eeprom_model_i (
    .cs_n(cs_n_oe ? cs_n_out : 1'b1), .sclk(sclk_oe & sclk_out),
    .sdo(sdo_oe & sdo_out), .sdi(sdi_pin));
  always #5 clock = ~clock;
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic test_done;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic t_idle;
    repeat (50) @(negedge clock);
    chk({cs_n_oe, sclk_oe, sdo_oe, cs_n_out, boot_active, cmd_valid}, 32'h4);
    $display("test idle done");
  endtask : t_idle
  task automatic t_start;
    int n;
    @(posedge clock);
    boot_mode_pin <= 1'b1;
    for (n = 0; n < 100 && cs_n_out !== 1'b0; n++) @(negedge clock);
    chk({cs_n_oe, sclk_oe, sdo_oe, boot_active}, 32'hF);
    chk({sclk_out, sdo_out}, 32'h0);
    $display("test start done");
  endtask : t_start
  task automatic t_stream;
    int n;
    int r0;
    for (int k = 0; k < 7; k++) begin
      // Clock enable low mid-stream: no link edge, nothing handed over
      if (k == 4) begin
        @(posedge clock);
        clk_en <= 1'b0;
        @(negedge clock);
        r0 = ebl_eeprom_model_i.rises;
        repeat (30) @(negedge clock);
        chk(ebl_eeprom_model_i.rises, r0);
        chk({cs_n_out, cmd_valid}, 32'h0);
        @(posedge clock);
        clk_en <= 1'b1;
      end
      for (n = 0; n < 1000 && cmd_valid !== 1'b1; n++) @(negedge clock);
      if (k == 0) chk(cmd_data, 24'h000061);
      if (k == 4) chk(cmd_data, 24'h000004);
      chk(cmd_opcode, exp_cmd[k]);
      chk(cmd_data, exp_dat[k]);
      chk(cmd_has_data, exp_cmd[k][7:6] == 2'h1);
      chk(cs_n_out, 1'h0);
      if (k == 2) begin
        bad = 0;
        repeat (40) begin
          @(negedge clock);
          if (sclk_out !== 1'b0 || cmd_valid !== 1'b1) bad++;
        end
        chk(bad, 32'h0);
        chk(cmd_data, exp_dat[k]);
      end
      @(posedge clock);
      cmd_ready <= 1'b1;
      @(posedge clock);
      cmd_ready <= 1'b0;
      @(negedge clock);
      if (k < 6) chk(cmd_valid, 1'h0);
    end
    $display("test stream done");
  endtask : t_stream
  task automatic t_stop;
    chk({boot_done, boot_active, cs_n_out}, 32'h5);
    repeat (200) @(negedge clock);
    chk(ebl_eeprom_model_i.rises, 8 + 8 + 8 * nbytes);
    chk(ebl_eeprom_model_i.opcode, 8'h03);
    chk(ebl_eeprom_model_i.addr, 16'h0000);
    chk({boot_done, cs_n_out, cmd_valid}, 32'h6);
    $display("test stop done");
  endtask : t_stop
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    clk_en = 1'b1;
    boot_mode_pin = 1'b0;
    cmd_ready = 1'b0;
    errors = 0;
    total_checks = 0;
    cycles = 0;
    nbytes = 0;
    for (int i = 0; i < 32; i++) ebl_eeprom_model_i.mem[i] = 8'h40;
    for (int k = 0; k < 7; k++) begin
      ebl_eeprom_model_i.mem[nbytes] = exp_cmd[k];
      nbytes++;
      if (exp_cmd[k][7:6] == 2'h1) begin
        for (int b = 2; b >= 0; b--) begin
          ebl_eeprom_model_i.mem[nbytes] = exp_dat[k][8*b +: 8];
          nbytes++;
        end
      end
    end
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    t_idle();
    t_start();
    t_stream();
    t_stop();
    test_done();
  end
endmodule : ebl_boot_loader_test
`default_nettype wire
